/* rtl/gpio_pkg.sv */
package gpio_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;                 // register address width
   localparam int DATA_W = 8;                 // register data width
   localparam int PIN_W = 6;                  // implemented port pins
   localparam int SYNC_STAGES = 2;            // flops in front of pin logic

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PIN_DATA_OFS = 8'h07;          // pin level / output latch
   localparam logic [7:0] PIN_DIRECTION_OFS = 8'h87;     // per-pin direction
   localparam logic [7:0] ANALOG_PIN_SELECT_OFS = 8'h91; // analog select

   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] UNUSED_TOP = 2'h0;             // bits 7-6 read as zero
   localparam logic [5:0] DIRECTION_RESET = 6'h3F;       // every pin an input
   localparam logic [7:0] ANALOG_SELECT_RESET = 8'hFF;   // every channel analog
   localparam logic [5:0] DATA_POR_VALUE = 6'h00;        // latch after power-up
   localparam logic [7:0] READ_ZERO = 8'h00;             // unmapped read value
   localparam int ANALOG_PINS = 4;                       // pins 0..3 share a channel
   localparam int ANALOG_BIT_BASE = 4;                   // pin i uses select bit i+4

   // ----------------------------------------------------------------
   // register select decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_DATA = 2'b01,
      SEL_DIR = 2'b10,
      SEL_ANALOG = 2'b11
   } reg_sel_t;

   // used by both the write path and the read path
   function automatic reg_sel_t reg_sel_f(input logic [7:0] addr, input logic has_analog);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr == PIN_DATA_OFS) begin
         sel = SEL_DATA;
      end else if (addr == PIN_DIRECTION_OFS) begin
         sel = SEL_DIR;
      end else if (has_analog && (addr == ANALOG_PIN_SELECT_OFS)) begin
         sel = SEL_ANALOG;
      end
      return sel;
   endfunction : reg_sel_f

endpackage : gpio_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// two-flop synchroniser for the asynchronous pin levels
// ----------------------------------------------------------------
module pin_sync
   import gpio_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [PIN_W-1:0] async_in,
   output logic [PIN_W-1:0] sync_out
);

   logic [PIN_W-1:0] meta_reg;   // first stage, read only by the second stage
   logic [PIN_W-1:0] stable_reg; // second stage, safe for logic

   // one small chain per pin; no logic looks at meta_reg
   genvar i;
   generate
      for (i = 0; i < PIN_W; i++) begin : g_bit
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               stable_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= async_in[i];
               stable_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign sync_out = stable_reg;

endmodule : pin_sync

/* rtl/read_mux.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// registered read data path
// ----------------------------------------------------------------
module read_mux
   import gpio_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rd_en,
   input wire reg_sel_t rd_sel,
   input wire logic [PIN_W-1:0] pin_level,
   input wire logic [PIN_W-1:0] direction,
   input wire logic [DATA_W-1:0] analog_select,
   output logic [DATA_W-1:0] rd_data
);

   logic [DATA_W-1:0] rd_data_reg;  // answer, valid the cycle after rd_en
   logic [DATA_W-1:0] rd_data_next; // selected word

   // pick the word; the top two bits of port registers are always zero
   always_comb begin
      case (rd_sel)
         SEL_DATA: rd_data_next = {UNUSED_TOP, pin_level};
         SEL_DIR: rd_data_next = {UNUSED_TOP, direction};
         SEL_ANALOG: rd_data_next = analog_select;
         default: rd_data_next = READ_ZERO;
      endcase
   end

   // only a read strobe updates the answer, so it stands one cycle and
   // is then returned to zero to keep stale data off the bus
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_data_reg <= READ_ZERO;
      end else if (rd_en) begin
         rd_data_reg <= rd_data_next;
      end else begin
         rd_data_reg <= READ_ZERO;
      end
   end

   assign rd_data = rd_data_reg;

endmodule : read_mux

/* rtl/gpio_port.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps

module gpio_port
   import gpio_pkg::*;
#(
   parameter bit HAS_ANALOG = 1'b1   // variant with the converter
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reset_from_power,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   input wire logic [PIN_W-1:0] pin_in,
   output logic [PIN_W-1:0] pin_out,
   output logic [PIN_W-1:0] pin_oe,
   output logic [DATA_W-1:0] analog_select
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] latch_reg;          // output latch behind the data register
   logic [PIN_W-1:0] latch_next;         // its next value
   logic [PIN_W-1:0] direction_reg;      // one = input, zero = output
   logic [PIN_W-1:0] direction_next;     // its next value
   logic [PIN_W-1:0] oe_reg;             // registered driver enable
   logic [DATA_W-1:0] analog_reg;        // analog select bits
   logic [DATA_W-1:0] analog_next;       // its next value
   logic [PIN_W-1:0] pin_sampled;        // synchronised pin levels
   logic [PIN_W-1:0] analog_mask;        // pins currently analog
   logic [PIN_W-1:0] pin_read;           // levels as software sees them
   reg_sel_t wr_sel;                     // decoded write target
   reg_sel_t rd_sel;                     // decoded read target

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------

   // the analog register simply is not there in the small variant
   assign wr_sel = reg_sel_f(addr, HAS_ANALOG);
   assign rd_sel = reg_sel_f(addr, HAS_ANALOG);

   // ----------------------------------------------------------------
   // pin input path
   // ----------------------------------------------------------------

   // pins are asynchronous to the core clock
   pin_sync u_pin_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(pin_in),
      .sync_out(pin_sampled)
   );

   // which pins are parked on an analog channel; software must clear
   // these before trusting a digital read
   genvar i;
   generate
      for (i = 0; i < PIN_W; i++) begin : g_mask
         if (HAS_ANALOG && (i < ANALOG_PINS)) begin : g_an
            assign analog_mask[i] = analog_reg[i + ANALOG_BIT_BASE];
         end else begin : g_dig
            assign analog_mask[i] = 1'b0;
         end
      end
   endgenerate

   // a pin edge shows up in a read issued two cycles later, since the
   // answer is registered behind the two synchroniser flops
   // analog pins read zero whatever voltage they carry
   assign pin_read = pin_sampled & ~analog_mask;

   // ----------------------------------------------------------------
   // output latch
   // ----------------------------------------------------------------

   // writes land in the latch, not on the pin; bits 7-6 are dropped
   always_comb begin
      latch_next = latch_reg;
      if (wr_en && (wr_sel == SEL_DATA)) begin
         latch_next = wr_data[PIN_W-1:0];
      end
   end

   // power-up gives a known latch; any other reset keeps what was written
   // zero on power-up is our own pick; software must not rely on it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         if (reset_from_power) begin
            latch_reg <= DATA_POR_VALUE;
         end else begin
            latch_reg <= latch_reg;
         end
      end else begin
         latch_reg <= latch_next;
      end
   end

   // ----------------------------------------------------------------
   // direction
   // ----------------------------------------------------------------

   // only the low six bits exist
   always_comb begin
      direction_next = direction_reg;
      if (wr_en && (wr_sel == SEL_DIR)) begin
         direction_next = wr_data[PIN_W-1:0];
      end
   end

   // every reset kind releases all drivers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         direction_reg <= DIRECTION_RESET;
      end else begin
         direction_reg <= direction_next;
      end
   end

   // driver enable is its own flop so the pad sees a clean edge;
   // it tracks the direction register with no extra latency
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         oe_reg <= ~DIRECTION_RESET;
      end else begin
         oe_reg <= ~direction_next;
      end
   end

   // ----------------------------------------------------------------
   // analog select
   // ----------------------------------------------------------------

   // writes only reach the register in the converter variant
   always_comb begin
      analog_next = analog_reg;
      if (wr_en && (wr_sel == SEL_ANALOG)) begin
         analog_next = wr_data;
      end
   end

   // every reset parks the shared pins in analog mode; in the small
   // variant the register stays zero so no pin is ever masked
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         analog_reg <= HAS_ANALOG ? ANALOG_SELECT_RESET : READ_ZERO;
      end else begin
         analog_reg <= analog_next;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------

   read_mux u_read_mux (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rd_en(rd_en),
      .rd_sel(rd_sel),
      .pin_level(pin_read),
      .direction(direction_reg),
      .analog_select(analog_reg),
      .rd_data(rd_data)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // all three come straight from flops so the pads never see decode glitches
   // the latch always reaches the pad; oe decides whether it is heard
   assign pin_out = latch_reg;
   assign pin_oe = oe_reg;
   assign analog_select = analog_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // a read of the data register
   sequence rd_data_s;
      rd_en && (addr == PIN_DATA_OFS);
   endsequence

   // a read of the direction register
   sequence rd_dir_s;
      rd_en && (addr == PIN_DIRECTION_OFS);
   endsequence

   // a write of the direction register
   sequence wr_dir_s;
      wr_en && (addr == PIN_DIRECTION_OFS);
   endsequence

   // a write of the data register
   sequence wr_latch_s;
      wr_en && (addr == PIN_DATA_OFS);
   endsequence

   // a write of the analog select register, converter variant only
   sequence wr_analog_s;
      HAS_ANALOG && wr_en && (addr == ANALOG_PIN_SELECT_OFS);
   endsequence

   // a read of an address that holds no register at all
   sequence rd_unmapped_s;
      rd_en && (addr != PIN_DATA_OFS) && (addr != PIN_DIRECTION_OFS) && (addr != ANALOG_PIN_SELECT_OFS);
   endsequence

   // top bits read zero on both port registers
   top_bits_zero_a: assert property ((rd_data_s or rd_dir_s) |=> rd_data[7:6] == 2'h0)
      else $error("unimplemented bits read nonzero");

   // data read returns masked pin level of the previous cycle
   pin_level_read_a: assert property (rd_data_s |=> rd_data[5:0] == $past(pin_sampled & ~analog_mask))
      else $error("data read does not match pin level");

   // pins 4 and 5 have no analog channel and always read their level
   digital_pins_read_a: assert property (rd_data_s |=> rd_data[5:4] == $past(pin_sampled[5:4]))
      else $error("digital-only pin read wrong level");

   // direction write moves drivers in the next cycle
   dir_drives_pin_a: assert property (wr_dir_s |=> pin_oe == ~$past(wr_data[5:0]))
      else $error("driver enable does not follow direction");

   // direction readback is the inverse of the driver enables
   dir_readback_a: assert property (rd_dir_s |=> rd_data[5:0] == ~$past(pin_oe))
      else $error("direction readback disagrees with drivers");

   // drivers only move on a direction write
   dir_hold_a: assert property (!(wr_en && (addr == PIN_DIRECTION_OFS)) |=> $stable(pin_oe))
      else $error("driver enable changed without a write");

   // after any reset every pin is an input; reset is the trigger here,
   // so the default reset switch-off must not apply
   reset_all_input_a: assert property (@(posedge ref_clk) disable iff (1'b0) !rst_n |=> pin_oe == 6'h00)
      else $error("driver enabled after reset");

   // a non-power reset keeps the output latch
   latch_kept_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      (!rst_n && !reset_from_power) |=> $stable(pin_out))
      else $error("latch changed on warm reset");

   // the latch only moves on a data write
   latch_hold_a: assert property (!(wr_en && (addr == PIN_DATA_OFS)) |=> $stable(pin_out))
      else $error("output latch changed without a write");

   // data write reaches the latch and stays while no write follows
   latch_load_a: assert property (wr_latch_s ##1 (!wr_en) [*2] |-> pin_out == $past(wr_data[5:0], 2))
      else $error("output latch not loaded");

   // with no read strobe the answer returns to zero next cycle
   read_idle_zero_a: assert property (!rd_en |=> rd_data == READ_ZERO)
      else $error("read data stood longer than one cycle");

   // addresses with no register answer zero
   unmapped_read_zero_a: assert property (rd_unmapped_s |=> rd_data == READ_ZERO)
      else $error("unmapped address read nonzero");

   // pin 0, when analog, answers zero in the read that follows
   analog_reads_zero_a: assert property (rd_data_s ##0 (analog_mask[0]) |=> !rd_data[0])
      else $error("analog pin read nonzero");

   // small variant answers zero at the analog select offset
   no_analog_reg_a: assert property ((!HAS_ANALOG && rd_en && addr == ANALOG_PIN_SELECT_OFS)
      |=> rd_data == 8'h00)
      else $error("analog select present in small variant");

   // small variant has no analog select bits to drive
   small_no_analog_a: assert property (!HAS_ANALOG |-> analog_select == READ_ZERO)
      else $error("analog select nonzero in small variant");

   // analog select write lands in the next cycle
   analog_load_a: assert property (wr_analog_s |=> analog_select == $past(wr_data))
      else $error("analog select write lost");

   // analog select only moves on its own write
   analog_hold_a: assert property (!(wr_en && (addr == ANALOG_PIN_SELECT_OFS)) |=> $stable(analog_select))
      else $error("analog select changed without a write");

   // every reset leaves all analog selects set
   analog_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      (HAS_ANALOG && !rst_n) |=> analog_select == 8'hFF)
      else $error("analog select not all ones after reset");

endmodule : gpio_port

/* tb/pin_board.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// board model: each pin is driven by the port or by outside circuitry
// ----------------------------------------------------------------
module pin_board
   import gpio_pkg::*;
(
   input wire logic [PIN_W-1:0] pin_out,
   input wire logic [PIN_W-1:0] pin_oe,
   input wire logic [PIN_W-1:0] ext_level,
   output logic [PIN_W-1:0] pin_in
);
   // a driven pin shows the latch, a released pin follows the outside source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_board

/* tb/six_bit_gpio_port_test.sv */
`timescale 1ns/100ps

module six_bit_gpio_port_test;
   import gpio_pkg::*;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_from_power = 1'b1; // start with a power-up reset
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] rd_data, rd_data2, analog_select, analog_select2, got, got2;
   logic [5:0] pin_in, pin_out, pin_oe;
   logic [5:0] ext_level = 6'h00; // outside source for released pins
   logic [7:0] d, r, a, e;
   int err_count = 0;
   int checks = 0;
   int seed = 32'h4ccf;

   always #12.5 ref_clk = ~ref_clk;

   gpio_port #(.HAS_ANALOG(1'b1)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reset_from_power(reset_from_power),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .analog_select(analog_select));
   // small variant shares the bus; only its analog select and its reads of the analog select offset are judged
   gpio_port #(.HAS_ANALOG(1'b0)) DUT2 (.ref_clk(ref_clk), .rst_n(rst_n), .reset_from_power(reset_from_power),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data2), .pin_in(pin_in),
      .pin_out(), .pin_oe(), .analog_select(analog_select2));
   pin_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

   // ----------------------------------------------------------------
   // bus tasks, compare and expectation
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      checks++;
      if (g !== x) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask : chk

   // #1 lets the edge's register updates land before anyone looks
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge ref_clk);
      addr <= ad;
      wr_data <= dt;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] ad);
      @(posedge ref_clk);
      addr <= ad;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      got = rd_data;
      got2 = rd_data2;
   endtask : rd

   // pin level seen by a read, with analog channels forced low
   function automatic logic [7:0] exp_read(input logic [5:0] dir, dat, ext, input logic [7:0] ana);
      logic [5:0] lvl;
      lvl = (~dir & dat) | (dir & ext);
      for (int i = 0; i < ANALOG_PINS; i++) begin
         lvl[i] = lvl[i] & ~ana[i + ANALOG_BIT_BASE];
      end
      return {2'b00, lvl};
   endfunction : exp_read

   task automatic test_done();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      test_done();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      reset_from_power <= 1'b0;
      rd(PIN_DIRECTION_OFS);
      chk(got, 8'h3F);
      rd(ANALOG_PIN_SELECT_OFS);
      chk(got, 8'hFF);
      chk(got2, 8'h00);
      @(posedge ref_clk);
      #1;
      chk(rd_data, 8'h00);
      chk({2'b00, pin_oe}, 8'h00);
      chk({2'b00, pin_out}, 8'h00);
      // unmapped place: ignored on write, zero on read
      wr(8'h10, 8'h00);
      rd(8'h10);
      chk(got, 8'h00);
      rd(PIN_DIRECTION_OFS);
      chk(got, 8'h3F);
      // deselect analog first so digital reads mean something
      wr(ANALOG_PIN_SELECT_OFS, 8'h00);
      for (int n = 0; n < 40; n++) begin
         d = 8'($random(seed));
         r = 8'($random(seed));
         e = 8'($random(seed));
         a = (n < 20) ? 8'h00 : 8'($random(seed));
         if (n == 0) begin
            d = 8'hFF;
            r = 8'hFF;
         end
         if (n == 1) begin
            r = 8'hC0;
         end
         ext_level <= e[5:0];
         wr(PIN_DIRECTION_OFS, r);
         chk({2'b00, pin_oe}, {2'b00, ~r[5:0]});
         wr(PIN_DATA_OFS, d);
         chk({2'b00, pin_out}, {2'b00, d[5:0]});
         // idle cycle so the latch is seen to hold with no write behind it
         @(posedge ref_clk);
         wr(ANALOG_PIN_SELECT_OFS, a);
         repeat (3) @(posedge ref_clk);
         rd(PIN_DATA_OFS);
         chk(got, exp_read(r[5:0], d[5:0], e[5:0], a));
         rd(PIN_DIRECTION_OFS);
         chk(got, {2'b00, r[5:0]});
         rd(ANALOG_PIN_SELECT_OFS);
         chk(got, a);
         chk(got2, 8'h00);
      end
      // warm reset keeps the latch, restores direction and analog select
      d = 8'hEA;
      wr(PIN_DATA_OFS, d);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk({2'b00, pin_out}, {2'b00, d[5:0]});
      chk({2'b00, pin_oe}, 8'h00);
      chk(analog_select, 8'hFF);
      chk(analog_select2, 8'h00);
      // power-up reset clears the latch
      @(posedge ref_clk);
      rst_n <= 1'b0;
      reset_from_power <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      reset_from_power <= 1'b0;
      #1;
      chk({2'b00, pin_out}, 8'h00);
      test_done();
   end
endmodule : six_bit_gpio_port_test
